/* File: rtl/timer16_pkg.sv */
// Purpose: Shared constants and types of the 16-bit capture/compare timer
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes:   All offsets are byte addresses

package timer16_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_CCC  = 8'h04;
	localparam logic [7:0] ADDR_OUT  = 8'h08;
	localparam logic [7:0] ADDR_CR0  = 8'h0C;
	localparam logic [7:0] ADDR_CR1  = 8'h10;
	localparam logic [7:0] ADDR_CNT  = 8'h14;
	localparam logic [7:0] ADDR_PRE  = 8'h18;
	localparam logic [7:0] ADDR_ST   = 8'h1C;
	localparam logic [7:0] ADDR_MSK  = 8'h20;

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int MODE_OVF  = 0;
	localparam int MODE_LO   = 2;
	localparam int OUT_OSPT  = 0;
	localparam int OUT_LVS   = 1;
	localparam int OUT_LVR   = 2;
	localparam int OUT_TOE   = 3;
	localparam int OUT_OSM   = 4;
	localparam int PRE_EXT   = 2;

	// ------------------------------------------------------------------
	// Values
	// ------------------------------------------------------------------
	localparam logic [15:0] CNT_MAX  = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_DEC = 2'h3;

	typedef enum logic [1:0] {
		MODE_STOP  = 2'b00,
		MODE_FREE  = 2'b01,
		MODE_EDGE  = 2'b10,
		MODE_MATCH = 2'b11
	} op_mode_t;

	typedef struct packed {
		logic [2:0]  cin_s;
		logic [2:0]  trg_s;
		logic [3:0]  pcnt;
		logic        phase;
		logic [15:0] cnt;
		logic [15:0] cr0;
		logic [15:0] cr1;
		logic        ovf;
		logic        ovf_win;
		logic        cap_pend;
		logic        edge_pend;
		logic        irq_pend;
		op_mode_t    mode;
		logic [1:0]  ccc;
		logic        toe;
		logic        osm;
		logic        lvl;
		logic        pin;
		logic        os_pend;
		logic [2:0]  pre;
		logic [2:0]  st;
		logic [2:0]  msk;
		logic        mci;
		logic [7:0]  awaddr;
		logic        aw_ok;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        w_ok;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} state_t;

endpackage

/* File: rtl/timer16_ccov.sv */
// Purpose: 16-bit timer/event counter with capture, compare and overflow
// Assumes: Pins are asynchronous; registers over AXI4-Lite
// Notes:   Count clock rise and fall are strobes derived from aclk, or from count_pin when PRE_EXT is set
//
// How it works
// - Wrap FFFFH to 0000H with compare zero at FFFFH sets overflow flag.
// - Clearing overflow before the count reaches 0001H is undone.
// - Capture latches the count on the count clock falling edge.
// - Capture interrupt rises at the following count clock rising edge.
// - Output level set and reset bits always read zero.
// - One-shot trigger bit clears itself and reads zero.
// - Counter stops while mode bits are 00, runs otherwise.

`timescale 1ns/100ps

module timer16_ccov #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output      logic              awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output      logic              wready,
	output      logic [1:0]        bresp,
	output      logic              bvalid,
	input  wire logic              bready,
	// AXI4-Lite read
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output      logic              arready,
	output      logic [31:0]       rdata,
	output      logic [1:0]        rresp,
	output      logic              rvalid,
	input  wire logic              rready,
	// Pins
	input  wire logic              count_pin,
	input  wire logic              trigger_edge_input,
	output      logic              timer_out,
	// Interrupts
	output      logic              match_capture_irq,
	output      logic              irq
);

	initial begin
		if (ADDR_W < 6 || ADDR_W > 8)
			$error("ADDR_W must be 6 to 8");
	end

	timer16_pkg::state_t s_q;
	timer16_pkg::state_t s_d;

	assign awready           = ~s_q.aw_ok & ~s_q.bvalid;
	assign wready            = ~s_q.w_ok & ~s_q.bvalid;
	assign bvalid            = s_q.bvalid;
	assign bresp             = s_q.bresp;
	assign arready           = ~s_q.rvalid;
	assign rvalid            = s_q.rvalid;
	assign rdata             = s_q.rdata;
	assign rresp             = s_q.rresp;
	assign timer_out         = s_q.pin;
	assign match_capture_irq = s_q.mci;
	assign irq               = |(s_q.st & s_q.msk);

	// ------------------------------------------------------------------
	// Register read view
	// ------------------------------------------------------------------
	function automatic logic [32:0] rd(input logic [7:0] a,
		input timer16_pkg::state_t s);
		logic [31:0] v;
		logic        hit;
		v   = 32'h0000_0000;
		hit = 1'b1;
		unique case (a)
			timer16_pkg::ADDR_MODE: begin
				v[timer16_pkg::MODE_OVF]       = s.ovf;
				v[timer16_pkg::MODE_LO+:2]     = s.mode;
			end
			timer16_pkg::ADDR_CCC: v[1:0]   = s.ccc;
			// Action bits are never stored
			timer16_pkg::ADDR_OUT: begin
				v[timer16_pkg::OUT_TOE] = s.toe;
				v[timer16_pkg::OUT_OSM] = s.osm;
			end
			timer16_pkg::ADDR_CR0: v[15:0]  = s.cr0;
			timer16_pkg::ADDR_CR1: v[15:0]  = s.cr1;
			timer16_pkg::ADDR_CNT: v[15:0]  = s.cnt;
			timer16_pkg::ADDR_PRE: v[2:0]   = s.pre;
			timer16_pkg::ADDR_ST:  v[2:0]   = s.st;
			timer16_pkg::ADDR_MSK: v[2:0]   = s.msk;
			default: hit = 1'b0;
		endcase
		return {hit, v};
	endfunction

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [32:0] rw;
		logic [31:0] be;
		logic [31:0] wv;
		logic [31:0] wm;
		logic        wr;
		logic        run;
		logic        rise;
		logic        fall;
		logic        crise;
		logic        cfall;
		logic        trg;
		logic        ovf_clr;
		logic        ovf_set;
		logic        m0;
		logic        m1;
		logic [2:0]  ev;
		logic [3:0]  hm1;
		logic [7:0]  a8;
		s_d     = s_q;
		rw      = 33'h0_0000_0000;
		be      = 32'h0000_0000;
		wv      = 32'h0000_0000;
		wm      = 32'h0000_0000;
		ovf_clr = 1'b0;
		ovf_set = 1'b0;
		m0      = 1'b0;
		m1      = 1'b0;
		ev      = 3'h0;
		a8      = 8'h00;
		wr      = 1'b0;
		run     = 1'b0;
		rise    = 1'b0;
		fall    = 1'b0;
		crise   = 1'b0;
		cfall   = 1'b0;
		trg     = 1'b0;
		hm1     = 4'h0;
		s_d.mci = 1'b0;

		// Pin synchronisers; edges seen only past the second stage
		s_d.cin_s = {s_q.cin_s[1:0], count_pin};
		s_d.trg_s = {s_q.trg_s[1:0], trigger_edge_input};
		crise     = s_q.cin_s[1] & ~s_q.cin_s[2];
		cfall     = ~s_q.cin_s[1] & s_q.cin_s[2];
		trg       = s_q.trg_s[1] & ~s_q.trg_s[2];

		// AXI write: address and data taken in either order
		if (awvalid && awready) begin
			s_d.awaddr = 8'(awaddr);
			s_d.aw_ok  = 1'b1;
		end
		if (wvalid && wready) begin
			s_d.wdata = wdata;
			s_d.wstrb = wstrb;
			s_d.w_ok  = 1'b1;
		end
		if (s_q.bvalid && bready)
			s_d.bvalid = 1'b0;
		wr = s_q.aw_ok & s_q.w_ok;
		if (wr) begin
			rw         = rd(s_q.awaddr, s_q);
			be         = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}},
				{8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
			wm         = s_q.wdata & be;
			wv         = (rw[31:0] & ~be) | wm;
			s_d.aw_ok  = 1'b0;
			s_d.w_ok   = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = rw[32] ? timer16_pkg::RESP_OK
				: timer16_pkg::RESP_DEC;
			unique case (s_q.awaddr)
				timer16_pkg::ADDR_MODE: begin
					s_d.mode = timer16_pkg::op_mode_t'(wv[timer16_pkg::MODE_LO+:2]);
					ovf_clr  = ~wv[timer16_pkg::MODE_OVF];
				end
				timer16_pkg::ADDR_CCC: s_d.ccc = wv[1:0];
				timer16_pkg::ADDR_OUT: begin
					s_d.toe = wv[timer16_pkg::OUT_TOE];
					s_d.osm = wv[timer16_pkg::OUT_OSM];
					if (wm[timer16_pkg::OUT_LVS])
						s_d.lvl = 1'b1;
					if (wm[timer16_pkg::OUT_LVR])
						s_d.lvl = 1'b0;
					// Trigger only arms a start, nothing is kept
					if (wm[timer16_pkg::OUT_OSPT] && s_d.osm)
						s_d.os_pend = 1'b1;
				end
				timer16_pkg::ADDR_CR0: s_d.cr0 = wv[15:0];
				timer16_pkg::ADDR_CR1: s_d.cr1 = wv[15:0];
				timer16_pkg::ADDR_PRE: s_d.pre = wv[2:0];
				timer16_pkg::ADDR_ST:  s_d.st  = s_q.st & ~wm[2:0];
				timer16_pkg::ADDR_MSK: s_d.msk = wv[2:0];
				default: ;
			endcase
		end

		// AXI read
		if (s_q.rvalid && rready)
			s_d.rvalid = 1'b0;
		if (arvalid && arready) begin
			a8         = 8'(araddr);
			rw         = rd(a8, s_q);
			s_d.rdata  = rw[31:0];
			s_d.rresp  = rw[32] ? timer16_pkg::RESP_OK
				: timer16_pkg::RESP_DEC;
			s_d.rvalid = 1'b1;
		end

		// ------------------------------------------------------------------
		// Count clock strobes
		// ------------------------------------------------------------------
		run  = (s_q.mode != timer16_pkg::MODE_STOP);
		hm1  = (4'h1 << s_q.pre[1:0]) - 4'h1;
		if (!run) begin
			s_d.pcnt  = 4'h0;
			s_d.phase = 1'b0;
		end else if (s_q.pcnt == 4'h0) begin
			s_d.pcnt  = hm1;
			s_d.phase = ~s_q.phase;
		end else begin
			s_d.pcnt = s_q.pcnt - 4'h1;
		end
		if (s_q.pre[timer16_pkg::PRE_EXT]) begin
			rise = run & crise;
			fall = run & cfall;
		end else begin
			rise = run & (s_q.pcnt == 4'h0) & ~s_q.phase;
			fall = run & (s_q.pcnt == 4'h0) & s_q.phase;
		end

		// ------------------------------------------------------------------
		// Counter, capture, compare
		// ------------------------------------------------------------------
		// Short trigger pulses still arm a capture; the wide pulse
		// the partner keeps is not needed; only its rising edge arms
		if (run && trg) begin
			s_d.cap_pend  = 1'b1;
			s_d.edge_pend = 1'b1;
		end
		if (fall && s_q.cap_pend) begin
			// Capture beats a software write of the same word
			if (s_q.ccc[0])
				s_d.cr0 = s_q.cnt;
			if (s_q.ccc[1])
				s_d.cr1 = s_q.cnt;
			s_d.cap_pend = trg;
			s_d.irq_pend = 1'b1;
		end
		if (rise) begin
			m0 = ~s_q.ccc[0] & (s_q.cnt == s_q.cr0);
			m1 = ~s_q.ccc[1] & (s_q.cnt == s_q.cr1);
			// Match-clear assumes compare zero is not a capture
			if (s_q.mode == timer16_pkg::MODE_MATCH && m0)
				s_d.cnt = timer16_pkg::CNT_ZERO;
			else if (s_q.mode == timer16_pkg::MODE_EDGE && s_q.edge_pend) begin
				s_d.cnt       = timer16_pkg::CNT_ZERO;
				s_d.edge_pend = trg;
			end else
				s_d.cnt = s_q.cnt + 16'h0001;
			ovf_set = (s_q.cnt == timer16_pkg::CNT_MAX) &
				(s_q.cr0 == timer16_pkg::CNT_MAX) &
				(s_d.cnt == timer16_pkg::CNT_ZERO);
			s_d.ovf_win = ovf_set;
			if (s_q.irq_pend || m0) begin
				s_d.mci      = 1'b1;
				s_d.irq_pend = 1'b0;
				ev[0]        = 1'b1;
			end
			ev[1] = m1;
			ev[2] = ovf_set;
			if (s_q.os_pend) begin
				s_d.lvl     = 1'b1;
				s_d.os_pend = 1'b0;
			end else if (m1)
				s_d.lvl = 1'b0;
			else if (m0 && !s_q.osm)
				s_d.lvl = 1'b1;
		end
		if (!run) begin
			// Stopped: count held at zero, nothing pending
			s_d.cnt       = timer16_pkg::CNT_ZERO;
			s_d.ovf_win   = 1'b0;
			s_d.cap_pend  = 1'b0;
			s_d.edge_pend = 1'b0;
			s_d.irq_pend  = 1'b0;
			s_d.os_pend   = 1'b0;
		end

		// Clear ignored inside the window; set wins
		s_d.ovf = (s_q.ovf & ~(ovf_clr & ~s_q.ovf_win)) | ovf_set;
		s_d.st  = s_d.st | ev;
		s_d.pin = s_d.toe & s_d.lvl;
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q      <= '0;
			s_q.mode <= timer16_pkg::MODE_STOP;
		end else begin
			s_q <= s_d;
		end
	end

endmodule

/* File: testbench/timer16_ccov_assertions.sv */
// Purpose: Port-level properties of the capture/compare timer
// Assumes: One aclk domain, synchronous active-low reset
// Notes:   Bound onto timer16_ccov below

`timescale 1ns/100ps

module timer16_ccov_assertions #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic              aclk,
	input wire logic              aresetn,
	// Bus
	input wire logic              awvalid,
	input wire logic              awready,
	input wire logic              wvalid,
	input wire logic              wready,
	input wire logic [1:0]        bresp,
	input wire logic              bvalid,
	input wire logic              bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic              arvalid,
	input wire logic              arready,
	input wire logic [31:0]       rdata,
	input wire logic [1:0]        rresp,
	input wire logic              rvalid,
	input wire logic              rready,
	// Events
	input wire logic              match_capture_irq
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_b_hold;
		bvalid && !bready |=> bvalid && $stable(bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_wr_lat;
		awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid;
	endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write response not two cycles on");
	property p_rd_lat;
		arvalid && arready |=> rvalid;
	endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read data not one cycle on");
	property p_ar_busy;
		rvalid |-> !arready;
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read taken while data pending");
	property p_mci_pulse;
		match_capture_irq |=> !match_capture_irq;
	endproperty
	a_mci_pulse: assert property (p_mci_pulse) else $error("event pulse too long");
	property p_out_zero;
		arvalid && arready && araddr == timer16_pkg::ADDR_OUT |=> rdata[2:0] == 3'h0;
	endproperty
	a_out_zero: assert property (p_out_zero) else $error("action bits read nonzero");
	property p_dec;
		arvalid && arready && araddr > 8'h23 |=> rresp == timer16_pkg::RESP_DEC;
	endproperty
	a_dec: assert property (p_dec) else $error("unmapped read not refused");
endmodule

bind timer16_ccov timer16_ccov_assertions #(.ADDR_W(ADDR_W)) u_chk (.aclk(aclk),
	.aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
	.rready(rready), .match_capture_irq(match_capture_irq));

/* File: testbench/pin_source.sv */
// Purpose: Far-side pins, capture trigger and external count input
// Assumes: Changes just after the aclk edge
// Notes:   Count input runs free; trigger length set by HOLD

`timescale 1ns/100ps

module pin_source #(
	parameter int HOLD = 16
) (
	// Command
	input wire logic aclk,
	input wire logic fire,
	// Pins
	output logic     trig,
	output logic     cnt
);
	int left = 0;

	initial begin
		trig = 1'b0;
		cnt = 1'b0;
	end

	// Pulse well over two count periods so the capture is reliable
	always @(posedge aclk) begin
		cnt <= ~cnt;
		if (fire && left == 0) begin
			trig <= 1'b1;
			left <= HOLD;
		end else if (left > 1) begin
			left <= left - 1;
		end else begin
			trig <= 1'b0;
			left <= 0;
		end
	end
endmodule

/* File: testbench/timer16_capture_compare_overflow_bench.sv */
// Purpose: Self-checking bench of the capture/compare timer
// Assumes: Response ready held back at random in the register loop
// Notes:   Overflow needs 65536 counts, beyond the run budget

`timescale 1ns/100ps

`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end

module timer16_capture_compare_overflow_bench;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr, araddr;
	logic        awvalid, wvalid, bready, arvalid, rready, fire;
	logic [31:0] wdata, rdata, d, v;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r;
	logic        awready, wready, bvalid, arready, rvalid, mci, irq, trig, cnt, tout;
	logic        slow = 1'b0, lv = 1'b0;
	logic [15:0] cap;
	int          mismatches = 0, compares = 0, cycles = 0, seed = 32'h8d90, n;
	int          top, ps, per;

	always #5 aclk = ~aclk;

	timer16_ccov u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.count_pin(cnt), .trigger_edge_input(trig), .timer_out(tout),
		.match_capture_irq(mci), .irq(irq));
	pin_source u_pins (.aclk(aclk), .fire(fire), .trig(trig), .cnt(cnt));

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	function automatic logic [4:0] exp_out(input logic [31:0] x);
		return {x[4:3], 3'h0};
	endfunction

	task automatic tally_and_finish();
		if (mismatches == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] resp);
		awaddr <= a;
		wdata <= x;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= ~slow;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && !bready) bready <= 1'b1;
		end while (!(bvalid && bready));
		resp = bresp;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] x, output logic [1:0] resp);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= ~slow;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && !rready) rready <= 1'b1;
		end while (!(rvalid && rready));
		x = rdata;
		resp = rresp;
	endtask

	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		{awaddr, araddr, wdata, wstrb} <= '0;
		{awvalid, wvalid, arvalid, fire} <= '0;
		{bready, rready} <= 2'b11;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rd(timer16_pkg::ADDR_MODE, v, r);
		`CHK(v, 32'h0)
		rd(timer16_pkg::ADDR_CNT, v, r);
		`CHK(v[15:0], 16'h0)
		`CHK(irq, 1'b0)
		for (n = 0; n < 6; n++) begin
			d = $random(seed);
			d[0] = d[0] & d[4];
			slow = d[7] | (n == 0);
			if (d[1]) lv = 1'b1;
			if (d[2]) lv = 1'b0;
			wr(timer16_pkg::ADDR_OUT, d, r);
			`CHK(tout, d[3] & lv)
			rd(timer16_pkg::ADDR_OUT, v, r);
			`CHK(v[4:0], exp_out(d))
			wr(timer16_pkg::ADDR_CR1, d, r);
			rd(timer16_pkg::ADDR_CR1, v, r);
			`CHK(v[15:0], d[15:0])
		end
		slow = 1'b0;
		wr(8'h24, d, r);
		`CHK(r, timer16_pkg::RESP_DEC)
		rd(8'h24, v, r);
		`CHK({r, v}, {timer16_pkg::RESP_DEC, 32'h0})
		wr(timer16_pkg::ADDR_CCC, 32'h1, r);
		wr(timer16_pkg::ADDR_PRE, 32'h0, r);
		wr(timer16_pkg::ADDR_MSK, 32'h1, r);
		wr(timer16_pkg::ADDR_MODE, 32'h4, r);
		rd(timer16_pkg::ADDR_CNT, v, r);
		`CHK(v[15:0] != 16'h0, 1'b1)
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		n = 0;
		while (mci !== 1'b1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		`CHK(mci, 1'b1)
		rd(timer16_pkg::ADDR_ST, v, r);
		`CHK(v[0], 1'b1)
		`CHK(irq, 1'b1)
		rd(timer16_pkg::ADDR_CR0, v, r);
		cap = v[15:0];
		rd(timer16_pkg::ADDR_CNT, v, r);
		`CHK(cap != 16'h0 && cap < v[15:0], 1'b1)
		wr(timer16_pkg::ADDR_MSK, 32'h0, r);
		`CHK(irq, 1'b0)
		wr(timer16_pkg::ADDR_MSK, 32'h1, r);
		`CHK(irq, 1'b1)
		wr(timer16_pkg::ADDR_ST, 32'h1, r);
		`CHK(irq, 1'b0)
		wr(timer16_pkg::ADDR_MODE, 32'h0, r);
		rd(timer16_pkg::ADDR_CNT, v, r);
		`CHK(v[15:0], 16'h0)
		// Match-clear period and output level, random prescale
		top = 4 + ($random(seed) & 15);
		ps = $random(seed) & 3;
		per = (2 << ps) * (top + 1);
		wr(timer16_pkg::ADDR_CCC, 32'h0, r);
		wr(timer16_pkg::ADDR_CR0, 32'(top), r);
		wr(timer16_pkg::ADDR_CR1, 32'hFFFE, r);
		wr(timer16_pkg::ADDR_PRE, 32'(ps), r);
		wr(timer16_pkg::ADDR_OUT, 32'hC, r);
		`CHK(tout, 1'b0)
		wr(timer16_pkg::ADDR_MODE, 32'hC, r);
		n = 0;
		while (mci !== 1'b1 && n < 800) begin
			@(posedge aclk);
			n++;
		end
		`CHK({mci, tout}, 2'b11)
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (mci !== 1'b1 && n < 800);
		`CHK(n, per)
		// One-shot pulse from the trigger bit, ended by compare one
		wr(timer16_pkg::ADDR_MODE, 32'h0, r);
		wr(timer16_pkg::ADDR_OUT, 32'h1C, r);
		`CHK(tout, 1'b0)
		wr(timer16_pkg::ADDR_CR1, 32'h1, r);
		wr(timer16_pkg::ADDR_MODE, 32'hC, r);
		wr(timer16_pkg::ADDR_OUT, 32'h19, r);
		n = 0;
		while (tout !== 1'b1 && n < 64) begin
			@(posedge aclk);
			n++;
		end
		`CHK(tout, 1'b1)
		n = 0;
		while (tout !== 1'b0 && n < per + 16) begin
			@(posedge aclk);
			n++;
		end
		`CHK(tout, 1'b0)
		// No new pulse over a whole period in one-shot mode
		repeat (per + 8) @(posedge aclk);
		`CHK(tout, 1'b0)
		// Trigger-edge clear on the external count input
		wr(timer16_pkg::ADDR_MODE, 32'h0, r);
		wr(timer16_pkg::ADDR_PRE, 32'h4, r);
		wr(timer16_pkg::ADDR_MODE, 32'h8, r);
		repeat (60) @(posedge aclk);
		rd(timer16_pkg::ADDR_CNT, v, r);
		`CHK(v[15:0] > 16'h0010, 1'b1)
		fire <= 1'b1;
		@(posedge aclk);
		fire <= 1'b0;
		n = 0;
		while (mci !== 1'b1 && n < 200) begin
			@(posedge aclk);
			n++;
		end
		`CHK(mci, 1'b1)
		rd(timer16_pkg::ADDR_CNT, v, r);
		`CHK(v[15:0] < 16'h0004, 1'b1)
		tally_and_finish();
	end
endmodule
